// ### verilog/usb_node_pkg.sv
package usb_node_pkg;

   // ****************************************************************
   // Register byte offsets on the AXI4-Lite bus.
   // ****************************************************************
   localparam logic [7:0] OFS_DMA_CONTROL = 8'h00;
   localparam logic [7:0] OFS_REVISION = 8'h04;
   localparam logic [7:0] OFS_NODE_STATE = 8'h08;
   localparam logic [7:0] OFS_MAIN_EVENT = 8'h0c;
   localparam logic [7:0] OFS_MAIN_MASK = 8'h10;

   // ****************************************************************
   // Field positions of the DMA control register.
   // ****************************************************************
   localparam int DMA_SEL_LSB = 0;
   localparam int DMA_SEL_MSB = 2;
   localparam int DMA_TIMING_BIT = 3;
   localparam int DMA_ENABLE_BIT = 7;
   localparam logic [2:0] DMA_SEL_LAST = 3'h5;

   // ****************************************************************
   // Node state field position and encodings.
   // ****************************************************************
   localparam int NODE_STATE_LSB = 0;
   localparam int NODE_STATE_MSB = 1;
   localparam logic [1:0] NODE_BUS_RESET_STATE = 2'h0;
   localparam logic [1:0] NODE_WAKEUP_STATE = 2'h1;
   localparam logic [1:0] NODE_ACTIVE_STATE = 2'h2;
   localparam logic [1:0] NODE_SLEEP_STATE = 2'h3;

   // ****************************************************************
   // Main event and main mask bit positions.
   // ****************************************************************
   localparam int EV_WARN = 0;
   localparam int EV_SECONDARY = 1;
   localparam int EV_TRANSMIT = 2;
   localparam int EV_FRAME = 3;
   localparam int EV_NAK = 4;
   localparam int EV_UNLOCK = 5;
   localparam int EV_RECEIVE = 6;
   localparam int EV_MASTER = 7;

   // ****************************************************************
   // Reset values, revision and bus responses.
   // ****************************************************************
   localparam logic [7:0] MAIN_EVENT_RESET = 8'h00;
   localparam logic [7:0] MAIN_MASK_RESET = 8'h00;
   localparam logic [2:0] DMA_SEL_RESET = 3'h0;
   // Arbitrary revision value.
   localparam logic [3:0] CHIP_REVISION = 4'h5;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### verilog/usb_node_dma_state_events.sv
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module usb_node_dma_state_events (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address channel.
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data channel.
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response channel.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address channel.
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data channel.
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Endpoint status, indexed by select code (0 is endpoint 1).
   input wire logic [5:0] ep_enable,
   input wire logic [5:0] ep_complete,
   input wire logic [5:0] ep_fifo_warn,
   input wire logic [5:0] ep_final_packet,
   input wire logic [5:0] ep_fifo_empty,
   input wire logic [5:0] ep_fifo_flush,
   // Host interface mode.
   input wire logic serial_host_mode,
   // DMA controller side.
   input wire logic dma_ack,
   output logic dma_req,
   // Event sources for the main summary, and bus activity for the resume detector.
   input wire logic warn_event_set,
   input wire logic warn_event_read,
   input wire logic secondary_event_set,
   input wire logic secondary_event_read,
   input wire logic nak_event_set,
   input wire logic nak_event_read,
   input wire logic tx_event_unmasked,
   input wire logic tx_status_any,
   input wire logic rx_event_unmasked,
   input wire logic rx_status_any,
   input wire logic frame_update,
   input wire logic unlock_event,
   input wire logic bus_activity,
   // Node state controls, resume flag and interrupt.
   output logic [1:0] node_state_field,
   output logic pipes_disable,
   output logic resume_k_drive,
   output logic xcvr_low_power,
   output logic node_freeze,
   output logic resume_detected_flag,
   output logic irq
);

   // ****************************************************************
   // State.
   // ****************************************************************
   typedef struct packed {
      logic aw_got;
      logic [7:0] awaddr;
      logic w_got;
      logic [7:0] wdata;
      logic wstrb0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [2:0] dma_sel;
      logic dma_timing;
      logic dma_en;
      logic dma_active;
      logic [1:0] node_state;
      logic [6:0] main_event;
      logic [7:0] main_mask;
      logic irq;
      logic dma_req;
      logic resume_pulse;
   } state_t;

   state_t state_ff;
   state_t nxt_state;

   logic do_write;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic wr_lane;
   logic rd_take;
   logic [7:0] rd_addr;
   logic [7:0] rd_byte;
   logic rd_hit;
   logic main_read;
   logic sel_ok;
   logic sel_tx;
   logic req_cond;
   logic [2:0] new_sel;
   logic [6:0] ev_set;
   logic [6:0] ev_hold;

   // ****************************************************************
   // Bus handshakes.
   // ****************************************************************
   assign s_axi_awready = !state_ff.aw_got && !state_ff.bvalid;
   assign s_axi_wready = !state_ff.w_got && !state_ff.bvalid;
   assign s_axi_arready = !state_ff.rvalid;
   assign s_axi_bvalid = state_ff.bvalid;
   assign s_axi_bresp = state_ff.bresp;
   assign s_axi_rvalid = state_ff.rvalid;
   assign s_axi_rresp = state_ff.rresp;
   assign s_axi_rdata = state_ff.rdata;

   // ****************************************************************
   // Outputs.
   // ****************************************************************
   assign dma_req = state_ff.dma_req;
   assign irq = state_ff.irq;
   assign node_state_field = state_ff.node_state;
   assign resume_detected_flag = state_ff.resume_pulse;
   // Pipes stay disabled for as long as the node sits in bus reset.
   assign pipes_disable =
      (state_ff.node_state == usb_node_pkg::NODE_BUS_RESET_STATE);
   assign resume_k_drive =
      (state_ff.node_state == usb_node_pkg::NODE_WAKEUP_STATE);
   assign xcvr_low_power =
      (state_ff.node_state == usb_node_pkg::NODE_SLEEP_STATE);
   assign node_freeze =
      (state_ff.node_state == usb_node_pkg::NODE_SLEEP_STATE);

   // ****************************************************************
   // Next state.
   // ****************************************************************
   always_comb begin
      nxt_state = state_ff;

      // Write address and data are taken in either order.
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_state.aw_got = 1'b1;
         nxt_state.awaddr = s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_state.w_got = 1'b1;
         nxt_state.wdata = s_axi_wdata[7:0];
         nxt_state.wstrb0 = s_axi_wstrb[0];
      end
      do_write = nxt_state.aw_got && nxt_state.w_got;
      wr_addr = nxt_state.awaddr;
      wr_data = nxt_state.wdata;
      wr_lane = nxt_state.wstrb0;
      if (s_axi_bvalid && s_axi_bready) begin
         nxt_state.bvalid = 1'b0;
      end
      if (do_write) begin
         nxt_state.aw_got = 1'b0;
         nxt_state.w_got = 1'b0;
         nxt_state.bvalid = 1'b1;
         nxt_state.bresp = usb_node_pkg::RESP_OKAY;
         unique case (wr_addr)
            usb_node_pkg::OFS_DMA_CONTROL,
            usb_node_pkg::OFS_REVISION,
            usb_node_pkg::OFS_NODE_STATE,
            usb_node_pkg::OFS_MAIN_EVENT,
            usb_node_pkg::OFS_MAIN_MASK: begin
            end
            default: begin
               nxt_state.bresp = usb_node_pkg::RESP_SLVERR;
            end
         endcase
      end

      // Register writes take effect only with byte lane 0 enabled.
      new_sel = wr_data[usb_node_pkg::DMA_SEL_MSB:usb_node_pkg::DMA_SEL_LSB];
      if (do_write && wr_lane) begin
         if (wr_addr == usb_node_pkg::OFS_DMA_CONTROL) begin
            if (new_sel <= usb_node_pkg::DMA_SEL_LAST) begin
               nxt_state.dma_sel = new_sel;
            end
            nxt_state.dma_timing = wr_data[usb_node_pkg::DMA_TIMING_BIT];
            nxt_state.dma_en = wr_data[usb_node_pkg::DMA_ENABLE_BIT];
         end
         if (wr_addr == usb_node_pkg::OFS_NODE_STATE) begin
            nxt_state.node_state = wr_data[usb_node_pkg::NODE_STATE_MSB:
               usb_node_pkg::NODE_STATE_LSB];
         end
         if (wr_addr == usb_node_pkg::OFS_MAIN_MASK) begin
            nxt_state.main_mask = wr_data;
         end
      end
      // Serial host mode holds DMA off whatever is written.
      if (serial_host_mode) begin
         nxt_state.dma_en = 1'b0;
      end

      // Read channel.
      if (s_axi_rvalid && s_axi_rready) begin
         nxt_state.rvalid = 1'b0;
      end
      rd_take = s_axi_arvalid && s_axi_arready;
      rd_addr = s_axi_araddr[7:0];
      rd_hit = 1'b1;
      unique case (rd_addr)
         usb_node_pkg::OFS_DMA_CONTROL: begin
            rd_byte = {state_ff.dma_en, 3'h0, state_ff.dma_timing,
               state_ff.dma_sel};
         end
         usb_node_pkg::OFS_REVISION: begin
            rd_byte = {4'h0, usb_node_pkg::CHIP_REVISION};
         end
         usb_node_pkg::OFS_NODE_STATE: begin
            rd_byte = {6'h00, state_ff.node_state};
         end
         usb_node_pkg::OFS_MAIN_EVENT: begin
            // The master bit always reads as zero.
            rd_byte = {1'b0, state_ff.main_event};
         end
         usb_node_pkg::OFS_MAIN_MASK: begin
            rd_byte = state_ff.main_mask;
         end
         default: begin
            rd_byte = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
      if (rd_take) begin
         nxt_state.rvalid = 1'b1;
         nxt_state.rdata = {24'h000000, rd_byte};
         nxt_state.rresp = rd_hit ? usb_node_pkg::RESP_OKAY :
            usb_node_pkg::RESP_SLVERR;
      end
      main_read = rd_take && (rd_addr == usb_node_pkg::OFS_MAIN_EVENT);

      // Main event bits; a set in the cycle of its clear wins.
      ev_set = 7'h00;
      ev_hold = state_ff.main_event;
      ev_set[usb_node_pkg::EV_WARN] = warn_event_set;
      if (warn_event_read) begin
         ev_hold[usb_node_pkg::EV_WARN] = 1'b0;
      end
      ev_set[usb_node_pkg::EV_SECONDARY] = secondary_event_set;
      if (secondary_event_read) begin
         ev_hold[usb_node_pkg::EV_SECONDARY] = 1'b0;
      end
      ev_set[usb_node_pkg::EV_NAK] = nak_event_set;
      if (nak_event_read) begin
         ev_hold[usb_node_pkg::EV_NAK] = 1'b0;
      end
      // Transmit and receive summaries hold until every status bit is gone.
      ev_set[usb_node_pkg::EV_TRANSMIT] = tx_event_unmasked;
      if (!tx_status_any) begin
         ev_hold[usb_node_pkg::EV_TRANSMIT] = 1'b0;
      end
      ev_set[usb_node_pkg::EV_RECEIVE] = rx_event_unmasked;
      if (!rx_status_any) begin
         ev_hold[usb_node_pkg::EV_RECEIVE] = 1'b0;
      end
      ev_set[usb_node_pkg::EV_FRAME] = frame_update;
      ev_set[usb_node_pkg::EV_UNLOCK] = unlock_event;
      if (main_read) begin
         ev_hold[usb_node_pkg::EV_FRAME] = 1'b0;
         ev_hold[usb_node_pkg::EV_UNLOCK] = 1'b0;
      end
      nxt_state.main_event = ev_set | ev_hold;

      // Interrupt follows the registered events and mask.
      nxt_state.irq = state_ff.main_mask[usb_node_pkg::EV_MASTER] &&
         |(state_ff.main_event & state_ff.main_mask[6:0]);

      // Bus activity while asleep raises the resume-detected flag.
      nxt_state.resume_pulse = bus_activity &&
         (state_ff.node_state == usb_node_pkg::NODE_SLEEP_STATE);

      // DMA stays live while enabled or while a granted cycle finishes.
      nxt_state.dma_active = nxt_state.dma_en ||
         (state_ff.dma_active && dma_ack);

      // Request condition for the selected endpoint.
      sel_ok = (state_ff.dma_sel <= usb_node_pkg::DMA_SEL_LAST);
      sel_tx = !state_ff.dma_sel[0];
      req_cond = 1'b0;
      if (sel_ok) begin
         if (!state_ff.dma_timing) begin
            if (sel_tx) begin
               req_cond = ep_complete[state_ff.dma_sel] &&
                  !ep_final_packet[state_ff.dma_sel];
            end else begin
               req_cond = ep_complete[state_ff.dma_sel] &&
                  !ep_fifo_empty[state_ff.dma_sel];
            end
         end else begin
            if (sel_tx) begin
               req_cond = ep_fifo_warn[state_ff.dma_sel] &&
                  !ep_complete[state_ff.dma_sel];
            end else begin
               req_cond = ep_fifo_warn[state_ff.dma_sel] &&
                  !ep_fifo_flush[state_ff.dma_sel];
            end
         end
      end
      // Frozen endpoints and a node in bus reset issue no requests.
      nxt_state.dma_req = req_cond && state_ff.dma_active &&
         ep_enable[state_ff.dma_sel] &&
         (state_ff.node_state != usb_node_pkg::NODE_SLEEP_STATE) &&
         (state_ff.node_state !=
         usb_node_pkg::NODE_BUS_RESET_STATE);
   end

   // ****************************************************************
   // State register.
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // All-zero reset puts the node in bus reset with DMA off.
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

endmodule // usb_node_dma_state_events

// ### bench/usb_node_dma_state_events_assertions.sv
`timescale 1ns/1ps
module usb_node_dma_state_events_assertions (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Read channel.
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   // Endpoint, mode, bus activity and request.
   input wire logic [5:0] ep_enable,
   input wire logic serial_host_mode,
   input wire logic bus_activity,
   input wire logic dma_req,
   // Node state outputs.
   input wire logic [1:0] node_state_field,
   input wire logic pipes_disable,
   input wire logic resume_k_drive,
   input wire logic xcvr_low_power,
   input wire logic node_freeze,
   input wire logic resume_detected_flag
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // ****************************************************************
   // Revision read: address taken, data returned on the next cycle.
   // ****************************************************************
   sequence rev_taken;
      s_axi_arvalid && s_axi_arready &&
      s_axi_araddr[7:0] == usb_node_pkg::OFS_REVISION;
   endsequence

   pipes_off_a:
      assert property (pipes_disable == (node_state_field == 2'h0))
      else $error("pipe disable does not match the node state");
   resume_k_a:
      assert property (resume_k_drive == (node_state_field == 2'h1))
      else $error("resume signalling does not match the node state");
   sleep_outputs_a:
      assert property (node_state_field == 2'h3 |-> xcvr_low_power && node_freeze)
      else $error("sleep state without low power and freeze");
   resume_flag_a:
      assert property (bus_activity && node_state_field == 2'h3 |=> resume_detected_flag)
      else $error("bus activity in sleep did not set the flag");
   flag_cause_a:
      assert property (resume_detected_flag |-> $past(bus_activity)
                       && $past(node_state_field) == 2'h3)
      else $error("resume flag without activity in sleep");
   req_state_a:
      assert property (dma_req |-> $past(node_state_field) inside {2'h1, 2'h2})
      else $error("request while pipes disabled or frozen");
   req_enable_a:
      assert property (dma_req |-> $past(ep_enable) != 6'h00)
      else $error("request with no endpoint enabled");
   serial_block_a:
      assert property ($rose(dma_req) |-> !$past(serial_host_mode))
      else $error("request raised in serial host mode");
   rev_read_a:
      assert property (rev_taken |=> s_axi_rvalid &&
         s_axi_rdata == {28'h0, usb_node_pkg::CHIP_REVISION})
      else $error("revision read returned a wrong value");
endmodule // usb_node_dma_state_events_assertions

bind usb_node_dma_state_events usb_node_dma_state_events_assertions
   i_usb_node_dma_state_events_assertions (
   .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .ep_enable(ep_enable), .serial_host_mode(serial_host_mode),
   .bus_activity(bus_activity), .dma_req(dma_req),
   .node_state_field(node_state_field), .pipes_disable(pipes_disable),
   .resume_k_drive(resume_k_drive), .xcvr_low_power(xcvr_low_power),
   .node_freeze(node_freeze), .resume_detected_flag(resume_detected_flag)
);

// ### bench/dma_responder.sv
`timescale 1ns/1ps
module dma_responder #(
   parameter int ACK_WAIT = 3
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Request in and stretch command from the bench.
   input wire logic dma_req,
   input wire logic hold,
   // Acknowledge back to the block.
   output logic dma_ack
);
   // ****************************************************************
   // Answers a request after a wait and runs a two-cycle transfer.
   // ****************************************************************
   int wait_ff;
   int len_ff;

   // The transfer is stretched while hold is high to model a slow cycle.
   always @(posedge aclk) begin
      if (!aresetn) begin
         dma_ack <= 1'b0;
         wait_ff <= 0;
         len_ff <= 0;
      end else if (dma_ack) begin
         len_ff <= len_ff + 1;
         if (!hold && len_ff >= 1) begin
            dma_ack <= 1'b0;
         end
      end else if (dma_req) begin
         wait_ff <= wait_ff + 1;
         if (wait_ff >= ACK_WAIT - 1) begin
            dma_ack <= 1'b1;
            wait_ff <= 0;
            len_ff <= 0;
         end
      end else begin
         wait_ff <= 0;
      end
   end
endmodule // dma_responder

// ### bench/usb_node_dma_state_events_bench.sv
`timescale 1ns/1ps
module usb_node_dma_state_events_bench;
   typedef struct packed {
      logic [7:0] ctl;
      logic [5:0] cmp, wrn, fin, emp, flu;
      logic [12:0] pul, lev;
      logic rq;
      logic [7:0] mev;
   } row_t;
   // ****************************************************************
   // Rows: control value, endpoint and event inputs, expected outputs.
   // ****************************************************************
   row_t rows [20] = '{
   '{8'h80,6'h01,6'h00,6'h00,6'h00,6'h00,13'h0000,13'h0000,1'b1,8'h00},
   '{8'h80,6'h01,6'h00,6'h01,6'h00,6'h00,13'h0000,13'h0000,1'b0,8'h00},
   '{8'h81,6'h02,6'h00,6'h00,6'h00,6'h00,13'h0000,13'h0000,1'b1,8'h00},
   '{8'h81,6'h02,6'h00,6'h00,6'h02,6'h00,13'h0000,13'h0000,1'b0,8'h00},
   '{8'h8a,6'h00,6'h04,6'h00,6'h00,6'h00,13'h0000,13'h0000,1'b1,8'h00},
   '{8'h8a,6'h04,6'h04,6'h00,6'h00,6'h00,13'h0000,13'h0000,1'b0,8'h00},
   '{8'h8b,6'h00,6'h08,6'h00,6'h00,6'h00,13'h0000,13'h0000,1'b1,8'h00},
   '{8'h8b,6'h00,6'h08,6'h00,6'h00,6'h08,13'h0000,13'h0000,1'b0,8'h00},
   '{8'h84,6'h10,6'h00,6'h00,6'h00,6'h00,13'h0000,13'h0000,1'b1,8'h00},
   '{8'h85,6'h20,6'h00,6'h00,6'h00,6'h00,13'h0000,13'h0000,1'b1,8'h00},
   '{8'h04,6'h10,6'h00,6'h00,6'h00,6'h00,13'h0000,13'h0000,1'b0,8'h00},
   '{8'h84,6'h01,6'h00,6'h00,6'h00,6'h00,13'h0000,13'h0000,1'b0,8'h00},
   '{8'h00,6'h00,6'h00,6'h00,6'h00,6'h00,13'h0001,13'h0000,1'b0,8'h01},
   '{8'h00,6'h00,6'h00,6'h00,6'h00,6'h00,13'h0006,13'h0000,1'b0,8'h02},
   '{8'h00,6'h00,6'h00,6'h00,6'h00,6'h00,13'h0018,13'h0000,1'b0,8'h10},
   '{8'h00,6'h00,6'h00,6'h00,6'h00,6'h00,13'h00e0,13'h0080,1'b0,8'h04},
   '{8'h00,6'h00,6'h00,6'h00,6'h00,6'h00,13'h0300,13'h0200,1'b0,8'h40},
   '{8'h00,6'h00,6'h00,6'h00,6'h00,6'h00,13'h0400,13'h0000,1'b0,8'h08},
   '{8'h00,6'h00,6'h00,6'h00,6'h00,6'h00,13'h0800,13'h0000,1'b0,8'h20},
   '{8'h00,6'h00,6'h00,6'h00,6'h00,6'h00,13'h0000,13'h0000,1'b0,8'h00}};
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, serial = 1'b0, hold = 1'b0;
   logic [5:0] ep_en = 6'h3f, cmp = 6'h00, wrn = 6'h00, fin = 6'h00;
   logic [5:0] emp = 6'h00, flu = 6'h00;
   logic [12:0] ev = 13'h0000;
   logic awready, wready, bvalid, arready, rvalid, dma_ack, dma_req;
   logic pipes, kdrv, lowp, frz, rflag, irq;
   logic [1:0] bresp, rresp, nsf, r;
   logic [31:0] rdata, d;
   int fail_count = 0;
   int checks_done = 0;
   int n;
   row_t t;
   always #2 aclk = ~aclk;
   usb_node_dma_state_events i_usb_node_dma_state_events (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .ep_enable(ep_en), .ep_complete(cmp),
      .ep_fifo_warn(wrn), .ep_final_packet(fin), .ep_fifo_empty(emp),
      .ep_fifo_flush(flu), .serial_host_mode(serial), .dma_ack(dma_ack),
      .dma_req(dma_req), .warn_event_set(ev[0]), .warn_event_read(ev[1]),
      .secondary_event_set(ev[2]), .secondary_event_read(ev[3]),
      .nak_event_set(ev[4]), .nak_event_read(ev[5]),
      .tx_event_unmasked(ev[6]), .tx_status_any(ev[7]),
      .rx_event_unmasked(ev[8]), .rx_status_any(ev[9]),
      .frame_update(ev[10]), .unlock_event(ev[11]), .bus_activity(ev[12]),
      .node_state_field(nsf), .pipes_disable(pipes), .resume_k_drive(kdrv),
      .xcvr_low_power(lowp), .node_freeze(frz),
      .resume_detected_flag(rflag), .irq(irq));
   dma_responder #(.ACK_WAIT(3)) i_dma_responder (
      .aclk(aclk), .aresetn(aresetn), .dma_req(dma_req), .hold(hold),
      .dma_ack(dma_ack));
   // ****************************************************************
   // Checking, bus and closing tasks.
   // ****************************************************************
   // Waits for the falling edge, then compares the values copied in at the call.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      @(negedge aclk);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic tmo(input int k);
      if (k >= 40) begin
         fail_count++;
         test_done();
      end
   endtask
   // Each bus task starts at a rising edge, consumes the response at a
   // rising edge and returns at the falling edge after it, so that the
   // registered outputs that follow the access have settled.
   task automatic axw(input logic [7:0] a, input logic [7:0] v);
      int k;
      logic ta, tw, tb;
      @(posedge aclk);
      {awaddr, wdata} <= {24'h0, a, 24'h0, v};
      {awvalid, wvalid, bready} <= 3'b111;
      for (k = 0; k < 40; k++) begin
         @(negedge aclk);
         {ta, tw, tb, r} = {awvalid & awready, wvalid & wready, bvalid, bresp};
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) break;
      end
      bready <= 1'b0;
      tmo(k);
      @(negedge aclk);
   endtask
   task automatic axr(input logic [7:0] a);
      int k;
      logic ta, tr;
      @(posedge aclk);
      araddr <= {24'h0, a};
      {arvalid, rready} <= 2'b11;
      for (k = 0; k < 40; k++) begin
         @(negedge aclk);
         {ta, tr, d, r} = {arvalid & arready, rvalid, rdata, rresp};
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
         if (tr) break;
      end
      rready <= 1'b0;
      tmo(k);
      @(negedge aclk);
   endtask
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      axr(usb_node_pkg::OFS_DMA_CONTROL);
      chk(d, 32'h0);
      axw(usb_node_pkg::OFS_REVISION, 8'hff);
      axr(usb_node_pkg::OFS_REVISION);
      chk(d, {28'h0, usb_node_pkg::CHIP_REVISION});
      axr(usb_node_pkg::OFS_NODE_STATE);
      chk({d[1:0], pipes}, 3'h1);
      axr(8'h14);
      chk({d[7:0], r}, {8'h00, usb_node_pkg::RESP_SLVERR});
      $display("reset and map test done");
      // Firmware walks the node through every state and then leaves sleep
      // for the active state; address bits are outside this block.
      // The resume state is held only briefly, since the block does not
      // time the wake-up; firmware owns that window.
      ev[12] <= 1'b1;
      for (int s = 0; s < 4; s++) begin
         axw(usb_node_pkg::OFS_NODE_STATE, 8'(s));
         chk({nsf, pipes, kdrv, lowp, frz},
             {s[1:0], s == 0, s == 1, s == 3, s == 3});
         chk(rflag, s == 3);
      end
      ev[12] <= 1'b0;
      axw(usb_node_pkg::OFS_NODE_STATE, 8'h02);
      $display("node state test done");
      foreach (rows[i]) begin
         t = rows[i];
         axw(usb_node_pkg::OFS_DMA_CONTROL, t.ctl);
         {cmp, wrn, fin, emp, flu, ev} <= {t.cmp, t.wrn, t.fin, t.emp, t.flu, t.pul};
         @(posedge aclk);
         ev <= t.lev;
         repeat (2) @(posedge aclk);
         chk(dma_req, t.rq);
         axr(usb_node_pkg::OFS_MAIN_EVENT);
         chk(d, t.mev);
         @(posedge aclk);
         {cmp, wrn, fin, emp, flu, ev} <= '0;
         repeat (4) @(posedge aclk);
      end
      $display("table test done");
      hold <= 1'b1;
      axw(usb_node_pkg::OFS_DMA_CONTROL, 8'h80);
      cmp <= 6'h01;
      for (n = 0; n < 40 && dma_ack !== 1'b1; n++) @(negedge aclk);
      tmo(n);
      axw(usb_node_pkg::OFS_DMA_CONTROL, 8'h00);
      chk(dma_req, 1'b1);
      hold <= 1'b0;
      repeat (6) @(posedge aclk);
      chk(dma_req, 1'b0);
      serial <= 1'b1;
      axw(usb_node_pkg::OFS_DMA_CONTROL, 8'h80);
      axr(usb_node_pkg::OFS_DMA_CONTROL);
      chk({d[7], dma_req}, 2'b00);
      {serial, ep_en} <= {1'b0, 6'h3e};
      axw(usb_node_pkg::OFS_DMA_CONTROL, 8'h80);
      chk(dma_req, 1'b0);
      ep_en <= 6'h3f;
      repeat (3) @(posedge aclk);
      chk(dma_req, 1'b1);
      axw(usb_node_pkg::OFS_DMA_CONTROL, 8'h81);
      axw(usb_node_pkg::OFS_DMA_CONTROL, 8'h8e);
      axr(usb_node_pkg::OFS_DMA_CONTROL);
      chk(d, 32'h89);
      cmp <= 6'h00;
      ev <= 13'h0001;
      @(posedge aclk);
      ev <= 13'h0000;
      axw(usb_node_pkg::OFS_MAIN_MASK, 8'h01);
      chk(irq, 1'b0);
      axw(usb_node_pkg::OFS_MAIN_MASK, 8'h81);
      chk(irq, 1'b1);
      ev <= 13'h0002;
      @(posedge aclk);
      ev <= 13'h0000;
      repeat (2) @(posedge aclk);
      chk(irq, 1'b0);
      $display("dma and interrupt test done");
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      axr(usb_node_pkg::OFS_NODE_STATE);
      chk({d[1:0], pipes, dma_req}, 4'h2);
      $display("second reset test done");
      test_done();
   end
endmodule // usb_node_dma_state_events_bench
